// ### bench/prc_run_control_tb.sv
// testbench: self-checking scenarios for processor run control
`timescale 1ns/100ps
module testbench;
   import prc_pkg::*;
   // ****************************************
   // clock, reset and host port
   // ****************************************
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        host_wr = 1'b0;
   logic        host_rd = 1'b0;
   logic [19:0] host_addr = 20'h0;
   logic [31:0] host_wdata = 32'h0;
   logic [31:0] host_rdata;
   logic        host_ack;
   logic        core_clk_en;
   logic        core_reset;
   logic        req_enable;
   logic        frame_tick;
   logic        core_running;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          n;
   localparam logic [31:0] RUN_ST = 32'h0000_0300;

   always #2.5 clk = ~clk;

   prc_run_control i_prc_run_control (
      .i_clk          (clk),
      .i_rst          (rst),
      .i_host_wr      (host_wr),
      .i_host_rd      (host_rd),
      .i_host_addr    (host_addr),
      .i_host_wdata   (host_wdata),
      .o_host_rdata   (host_rdata),
      .o_host_ack     (host_ack),
      .o_core_clk_en  (core_clk_en),
      .o_core_reset   (core_reset),
      .o_req_enable   (req_enable),
      .o_frame_tick   (frame_tick),
      .o_core_running (core_running)
   );

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // one strobe cycle; ack and read data stand in the cycle after the taking edge
   task automatic bus(input logic wr, input logic [19:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      host_wr <= wr;
      host_rd <= ~wr;
      host_addr <= a;
      host_wdata <= d;
      @(posedge clk);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      #1;
      q = host_rdata;
      chk({31'h0, host_ack}, 32'h1);
   endtask

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // bounded waits; exhausting the bound ends the run as a failure
   task automatic wait_run(input logic v);
      int k = 0;
      while (core_running !== v && k < 60) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 60) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   task automatic wait_tick(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (frame_tick !== 1'b1 && k < 40);
      if (k == 40) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   task automatic stays_stopped();
      wait_tick(n);
      wait_tick(n);
      chk({31'h0, core_running}, 32'h0);
   endtask

   // host view: poll the status register until the run flag shows v
   task automatic poll_run(input logic v);
      logic [31:0] q;
      int          k;
      k = 0;
      do begin
         bus(1'b0, PRC_STAT_OFS, 32'h0, q);
         k++;
      end while (q[PRC_RUNNING_BIT] !== v && k < 30);
      chk({30'h0, q[PRC_SLEEP_N_BIT], q[PRC_RUNNING_BIT]}, {30'h0, v, v});
      if (q[PRC_RUNNING_BIT] !== v) stop_test();
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk({30'h0, core_reset, req_enable}, 32'h0);
      rd(PRC_CTRL_OFS, PRC_CTRL_RST);
      rd(PRC_STAT_OFS, PRC_STAT_RST);
      rd(PRC_FRM_OFS, 32'h0);
      wr(PRC_STAT_OFS, 32'hffff_ffff);
      rd(PRC_STAT_OFS, 32'h0);
      rd(20'h30004, 32'h0);
   endtask

   task automatic t_timer();
      wr(PRC_FRM_OFS, 32'h4);
      rd(PRC_FRM_OFS, 32'h4);
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk(n, 32'h4);
   endtask

   task automatic t_start();
      wr(PRC_CTRL_OFS, 32'h25);
      chk({31'h0, req_enable}, 32'h1);
      wait_run(1'b1);
      chk({30'h0, frame_tick, core_clk_en}, 32'h3);
      rd(PRC_STAT_OFS, RUN_ST);
      rd(PRC_CTRL_OFS, 32'h21);
      wr(PRC_FRM_OFS, 32'h6);
      rd(PRC_FRM_OFS, 32'h6);
      wait_tick(n);
      wait_tick(n);
      chk(n, 32'h6);
   endtask

   task automatic t_stop_frame();
      wr(PRC_CTRL_OFS, 32'h23);
      wait_run(1'b0);
      chk({31'h0, frame_tick}, 32'h1);
      rd(PRC_CTRL_OFS, 32'h21);
      rd(PRC_STAT_OFS, 32'h0);
      stays_stopped();
   endtask

   task automatic t_gate();
      wr(PRC_CTRL_OFS, 32'h04);
      chk({31'h0, req_enable}, 32'h0);
      stays_stopped();
      wr(PRC_CTRL_OFS, 32'h21);
      wait_run(1'b1);
      chk({31'h0, frame_tick}, 32'h1);
      wr(PRC_CTRL_OFS, 32'h20);
      @(posedge clk);
      #1;
      chk({30'h0, core_running, core_clk_en}, 32'h0);
   endtask

   task automatic t_swreset();
      wr(PRC_CTRL_OFS, 32'h25);
      wait_run(1'b1);
      wr(PRC_CTRL_OFS, 32'h61);
      @(posedge clk);
      #1;
      chk({30'h0, core_reset, core_running}, 32'h2);
      stays_stopped();
      chk({31'h0, core_reset}, 32'h1);
      wr(PRC_CTRL_OFS, 32'h25);
      poll_run(1'b1);
      wait_run(1'b1);
      chk({31'h0, core_reset}, 32'h0);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_timer();
      t_start();
      t_stop_frame();
      t_gate();
      t_swreset();
      stop_test();
   end
endmodule

// ### verilog/prc_frame_timer.sv
// frame timer: counts processor clocks from the preload and pulses at each frame boundary
`timescale 1ns/100ps
module prc_frame_timer #(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_preload,
   output logic              o_tick
);
   import prc_pkg::*;

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_d;
   logic         expired;
   logic         enabled;

   // ****************************************
   // count down and reload
   // ****************************************
   // a zero preload stops frame boundaries instead of ticking every cycle
   assign enabled = (i_preload != '0);
   assign expired = (cnt_q == '0);
   assign tick_d  = expired & enabled;                              // RULE16
   assign cnt_d   = expired ? (enabled ? i_preload - W'(1) : '0)   // RULE12
                            : cnt_q - W'(1);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         o_tick <= tick_d;
      end
   end

endmodule

// ### verilog/prc_pkg.sv
// package: register map, field positions and reset values of processor run control
package prc_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int PRC_ADDR_W  = 20;
   localparam int PRC_DATA_W  = 32;
   localparam int PRC_FRAME_W = 16;

   // ****************************************
   // offsets within the second host window
   // ****************************************
   localparam logic [PRC_ADDR_W-1:0] PRC_CTRL_OFS = 20'h30000;
   localparam logic [PRC_ADDR_W-1:0] PRC_STAT_OFS = 20'h30028;
   localparam logic [PRC_ADDR_W-1:0] PRC_FRM_OFS  = 20'h30030;

   // ****************************************
   // processor_control fields
   // ****************************************
   localparam int PRC_RUN_BIT    = 0;
   localparam int PRC_STOP_FR_BIT = 1;
   localparam int PRC_RUN_FR_BIT = 2;
   localparam int PRC_REQ_EN_BIT = 5;
   localparam int PRC_SW_RST_BIT = 6;

   // ****************************************
   // processor_clock_status fields
   // ****************************************
   localparam int PRC_RUNNING_BIT = 8;
   localparam int PRC_SLEEP_N_BIT = 9;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [PRC_DATA_W-1:0]  PRC_CTRL_RST = 32'h0000_0000;
   localparam logic [PRC_DATA_W-1:0]  PRC_STAT_RST = 32'h0000_0000;
   localparam logic [PRC_FRAME_W-1:0] PRC_FRM_RST  = 16'h0000;

endpackage

// ### verilog/prc_run_control.sv
// processor run control: control, status and frame timer registers with run state
`timescale 1ns/100ps
// Function
// [RULE1] run bit low keeps processor stopped
// [RULE2] run bit high only permits execution
// [RULE3] run bit falling stops processor immediately
// [RULE4] stop-at-frame halts at boundary, then self-clears
// [RULE5] run-at-frame rising starts at boundary, self-clears
// [RULE6] request engine enabled only while bit set
// [RULE7] software reset bit holds processor in reset
// [RULE8] software reset equals hardware reset; code matches core reset and clock only, request enable and timer run on
// [RULE9] status bit 8 shows processor running
// [RULE10] status bit 9 low while clock stopped
// [RULE11] host polls status after control writes
// [RULE12] 16-bit preload sets clocks per frame
// [RULE13] preload readable and writable at any time
// [RULE14] control register at 30000h, fixed bit layout
// [RULE15] host keeps request enable set while running
// [RULE16] timer counts preload, ticks, then reloads
// [RULE17] running flag follows actual start and stop
module prc_run_control (
   input  wire logic                            i_clk,
   input  wire logic                            i_rst,
   input  wire logic                            i_host_wr,
   input  wire logic                            i_host_rd,
   input  wire logic [prc_pkg::PRC_ADDR_W-1:0]  i_host_addr,
   input  wire logic [prc_pkg::PRC_DATA_W-1:0]  i_host_wdata,
   output logic      [prc_pkg::PRC_DATA_W-1:0]  o_host_rdata,
   output logic                                 o_host_ack,
   output logic                                 o_core_clk_en,
   output logic                                 o_core_reset,
   output logic                                 o_req_enable,
   output logic                                 o_frame_tick,
   output logic                                 o_core_running
);
   import prc_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic                   run_q;
   logic                   run_d;
   logic                   stop_fr_q;
   logic                   stop_fr_d;
   logic                   run_fr_q;
   logic                   run_fr_d;
   logic                   req_en_q;
   logic                   req_en_d;
   logic                   sw_rst_q;
   logic                   sw_rst_d;
   logic                   core_run_q;
   logic                   core_run_d;
   logic [PRC_FRAME_W-1:0] frm_q;
   logic [PRC_FRAME_W-1:0] frm_d;
   logic [PRC_DATA_W-1:0]  rdata_d;
   logic [PRC_DATA_W-1:0]  ctrl_view;
   logic [PRC_DATA_W-1:0]  stat_view;
   logic [PRC_DATA_W-1:0]  frm_view;
   logic                   sel_ctrl;
   logic                   sel_stat;
   logic                   sel_frm;
   logic                   wr_ctrl;
   logic                   wr_frm;
   logic                   run_fr_rise;
   logic                   stop_fr_wr1;
   logic                   stop_done;
   logic                   start_exec;
   logic                   frame;
   logic                   hold_stop;

   // ****************************************
   // address decode
   // ****************************************
   assign sel_ctrl = (i_host_addr == PRC_CTRL_OFS);                // RULE14
   assign sel_stat = (i_host_addr == PRC_STAT_OFS);
   assign sel_frm  = (i_host_addr == PRC_FRM_OFS);
   assign wr_ctrl  = i_host_wr & sel_ctrl;
   // no gating on run state: the preload stays reachable in any state
   assign wr_frm   = i_host_wr & sel_frm;                          // RULE13

   // ****************************************
   // frame timer
   // ****************************************
   prc_frame_timer #(
      .W (PRC_FRAME_W)
   ) u_timer (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_preload (frm_q),
      .o_tick    (frame)
   );

   // ****************************************
   // control field next values
   // ****************************************
   assign run_d  = wr_ctrl ? i_host_wdata[PRC_RUN_BIT] : run_q;    // RULE14
   assign req_en_d = wr_ctrl ? i_host_wdata[PRC_REQ_EN_BIT] : req_en_q;  // RULE6
   assign sw_rst_d = wr_ctrl ? i_host_wdata[PRC_SW_RST_BIT] : sw_rst_q;  // RULE7
   assign frm_d  = wr_frm ? i_host_wdata[PRC_FRAME_W-1:0] : frm_q; // RULE12

   // only a 0-to-1 change arms a frame start; a steady 1 is ignored
   assign run_fr_rise = wr_ctrl & i_host_wdata[PRC_RUN_FR_BIT] & ~run_fr_q;  // RULE5
   assign stop_fr_wr1 = wr_ctrl & i_host_wdata[PRC_STOP_FR_BIT];

   // a pending stop is retired at the boundary whatever the run state
   assign stop_done  = frame & stop_fr_q;                          // RULE4
   // stop beats start in one frame; the start then waits one more frame
   assign start_exec = frame & run_fr_q & ~stop_fr_q & run_d & ~sw_rst_d;  // RULE5

   // set by a host write wins over the self-clear in the same cycle
   assign stop_fr_d = stop_fr_wr1 ? 1'b1
                    : wr_ctrl     ? 1'b0
                    : stop_done   ? 1'b0
                    : stop_fr_q;                                   // RULE4
   assign run_fr_d  = run_fr_rise ? 1'b1
                    : start_exec  ? 1'b0
                    : run_fr_q;                                    // RULE5

   // ****************************************
   // processor run state
   // ****************************************
   // run and reset use the incoming write so the stop needs no frame
   assign hold_stop  = ~run_d | sw_rst_d;                          // RULE1 RULE3 RULE7
   assign core_run_d = hold_stop  ? 1'b0
                     : stop_done  ? 1'b0
                     : start_exec ? 1'b1                           // RULE2
                     : core_run_q;                                 // RULE17

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_q      <= PRC_CTRL_RST[PRC_RUN_BIT];
         stop_fr_q  <= PRC_CTRL_RST[PRC_STOP_FR_BIT];
         run_fr_q   <= PRC_CTRL_RST[PRC_RUN_FR_BIT];
         req_en_q   <= PRC_CTRL_RST[PRC_REQ_EN_BIT];
         sw_rst_q   <= PRC_CTRL_RST[PRC_SW_RST_BIT];
         frm_q      <= PRC_FRM_RST;
         core_run_q <= PRC_STAT_RST[PRC_RUNNING_BIT];
      end else begin
         run_q      <= run_d;
         stop_fr_q  <= stop_fr_d;
         run_fr_q   <= run_fr_d;
         req_en_q   <= req_en_d;
         sw_rst_q   <= sw_rst_d;
         frm_q      <= frm_d;
         core_run_q <= core_run_d;
      end
   end

   // ****************************************
   // processor-facing outputs
   // ****************************************
   // hardware and software reset drive the very same core reset line
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_core_reset   <= 1'b1;                                   // RULE8
         o_core_clk_en  <= 1'b0;
         o_core_running <= 1'b0;
         o_req_enable   <= 1'b0;
         o_frame_tick   <= 1'b0;
      end else begin
         o_core_reset   <= sw_rst_d;                               // RULE7 RULE8
         o_core_clk_en  <= core_run_d;                             // RULE10
         o_core_running <= core_run_d;                             // RULE9
         o_req_enable   <= req_en_d;                               // RULE6
         o_frame_tick   <= frame;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   assign ctrl_view = PRC_DATA_W'({sw_rst_q, req_en_q, 2'b00, run_fr_q, stop_fr_q, run_q});
   assign stat_view = PRC_DATA_W'({core_run_q, core_run_q}) << PRC_RUNNING_BIT;  // RULE9 RULE10
   assign frm_view  = PRC_DATA_W'(frm_q);                          // RULE13
   // unmapped offsets read as zero
   assign rdata_d   = sel_ctrl ? ctrl_view
                    : sel_stat ? stat_view
                    : sel_frm  ? frm_view
                    : '0;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_host_rdata <= '0;
         o_host_ack   <= 1'b0;
      end else begin
         o_host_rdata <= i_host_rd ? rdata_d : '0;
         o_host_ack   <= i_host_rd | i_host_wr;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [PRC_FRAME_W:0]   gap_q;
   logic                   seen_q;
   logic [PRC_FRAME_W-1:0] frm_prev_q;
   logic [PRC_FRAME_W-1:0] period_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         gap_q      <= '0;
         seen_q     <= 1'b0;
         frm_prev_q <= '0;
         period_q   <= '0;
      end else begin
         gap_q      <= frame ? (PRC_FRAME_W+1)'(1) : gap_q + (PRC_FRAME_W+1)'(1);
         seen_q     <= seen_q | frame;
         // the reload at a boundary used the preload of the cycle before it
         frm_prev_q <= frm_q;
         period_q   <= frame ? frm_prev_q : period_q;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence stop_armed_s;
      frame && stop_fr_q && !wr_ctrl;
   endsequence

   sequence start_armed_s;
      start_exec && !run_fr_rise && !wr_ctrl;
   endsequence

   run_low_stop_a: assert property (!run_q |-> !core_run_q)       // RULE1
      else $error("processor runs while run bit is low");

   imm_stop_a: assert property ( // RULE3
      (wr_ctrl && !i_host_wdata[PRC_RUN_BIT] && core_run_q) |=> !o_core_running)
      else $error("run bit clear did not stop processor at once");

   frame_stop_a: assert property (stop_armed_s |=> !stop_fr_q && !core_run_q) // RULE4
      else $error("stop at frame not executed or not cleared");

   frame_start_a: assert property (start_armed_s |=> !run_fr_q && o_core_running) // RULE5
      else $error("run at frame not executed or not cleared");

   start_cause_a: assert property ( // RULE17
      $rose(core_run_q) |-> $past(frame) && $past(run_fr_q) && run_q)
      else $error("processor started without a frame start");

   req_gate_a: assert property ( // RULE6
      wr_ctrl |=> o_req_enable == $past(i_host_wdata[PRC_REQ_EN_BIT]))
      else $error("request enable does not follow control write");

   sw_rst_hold_a: assert property ( // RULE7
      sw_rst_q |-> o_core_reset && !o_core_running ##1 (sw_rst_q || !core_run_q))
      else $error("software reset not holding processor");

   status_read_a: assert property ( // RULE9 RULE10
      (i_host_rd && sel_stat) |=>
         o_host_rdata[PRC_RUNNING_BIT] == $past(core_run_q)
         && o_host_rdata[PRC_SLEEP_N_BIT] == $past(core_run_q))
      else $error("status bits do not show run state");

   frame_gap_a: assert property ( // RULE16
      (frame && seen_q) |-> gap_q == (PRC_FRAME_W+1)'(period_q))
      else $error("frame period differs from preload");

   preload_wr_a: assert property ( // RULE13
      wr_frm |=> frm_q == $past(i_host_wdata[PRC_FRAME_W-1:0]))
      else $error("preload write lost");

   bus_ack_a: assert property ((i_host_rd || i_host_wr) |=> o_host_ack) // RULE13
      else $error("host access not acknowledged");

   hw_reset_out_a: assert property ( // RULE8 RULE10
      $past(i_rst) |-> o_core_reset && !o_core_clk_en && !o_core_running && !o_req_enable)
      else $error("outputs not in reset state after hardware reset");

   sw_rst_equal_a: assert property (sw_rst_q |-> o_core_reset && !o_core_clk_en) // RULE8
      else $error("software reset differs from hardware reset");

   run_permit_a: assert property (o_core_running |-> run_q && !sw_rst_q) // RULE2 RULE7
      else $error("processor runs without run permission");

   idle_arm_a: assert property ( // RULE5
      (!run_fr_q && !(wr_ctrl && i_host_wdata[PRC_RUN_FR_BIT])) |=> !run_fr_q)
      else $error("run at frame armed without a rising write");

   start_wait_a: assert property ((run_fr_q && !frame) |=> run_fr_q) // RULE5
      else $error("pending frame start lost before a boundary");

   stop_wait_a: assert property ((stop_fr_q && !frame && !wr_ctrl) |=> stop_fr_q) // RULE4
      else $error("pending frame stop lost before a boundary");

   run_steady_a: assert property ((core_run_q && !frame && !wr_ctrl) |=> core_run_q) // RULE17
      else $error("processor stopped without a stop event");

   no_free_start_a: assert property ((!core_run_q && !frame) |=> !core_run_q) // RULE17
      else $error("processor started away from a frame boundary");

   req_steady_a: assert property (!wr_ctrl |=> $stable(o_req_enable)) // RULE6
      else $error("request enable changed without a control write");

   ctrl_read_a: assert property ( // RULE14
      (i_host_rd && sel_ctrl) |=> o_host_rdata[PRC_RUN_BIT] == $past(run_q)
         && o_host_rdata[PRC_REQ_EN_BIT] == $past(req_en_q)
         && o_host_rdata[PRC_SW_RST_BIT] == $past(sw_rst_q))
      else $error("control read-back differs from stored bits");

   frm_read_a: assert property ( // RULE13
      (i_host_rd && sel_frm) |=> o_host_rdata == PRC_DATA_W'($past(frm_q)))
      else $error("preload read-back differs from stored value");

endmodule
